// ### verilog/citaf_pkg.sv
// Package for the CAN interrupt, transmit abort and acceptance filter block
package citaf_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_RX_IRQ_ENABLE   = 8'h00;
  localparam logic [7:0] OFF_TX_FLAGS        = 8'h04;
  localparam logic [7:0] OFF_TX_CONTROL      = 8'h08;
  localparam logic [7:0] OFF_ACCEPT_CONTROL  = 8'h0c;
  localparam logic [7:0] OFF_RX_ERROR_COUNT  = 8'h10;
  localparam logic [7:0] OFF_TX_ERROR_COUNT  = 8'h14;
  localparam logic [7:0] OFF_ACCEPT_CODE_0   = 8'h20;
  localparam logic [7:0] OFF_ACCEPT_MASK_0   = 8'h30;
  localparam logic [7:0] OFF_MODULE_STATUS   = 8'h40;
  // Reset values
  localparam logic [7:0] RST_RX_IRQ_ENABLE   = 8'h00;
  localparam logic [2:0] RST_TX_EMPTY        = 3'h7;
  localparam logic [7:0] RST_BYTE            = 8'h00;
  // Field positions
  localparam int POS_TXE_IE    = 0;
  localparam int POS_ABORT_REQUEST     = 4;
  localparam int POS_TXE       = 0;
  localparam int POS_ABORT_ACK     = 4;
  localparam int POS_LAYOUT    = 4;
  localparam int POS_HIT       = 0;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Acceptance layouts
  typedef enum logic [1:0] {
    CITAF_ONE32  = 2'd0,
    CITAF_TWO16  = 2'd1,
    CITAF_FOUR8  = 2'd2,
    CITAF_CLOSED = 2'd3
  } citaf_layout_t;

  // Receive status flags: wakeup, error class, overrun and full
  typedef struct packed {
    logic wakeup;
    logic rxWarning;
    logic txWarning;
    logic rxPassive;
    logic txPassive;
    logic busoff;
    logic overrun;
    logic rxFull;
  } citaf_rxflags_t;

  // Transmit engine result per buffer
  typedef struct packed {
    logic [2:0] sent;
    logic [2:0] abortable;
  } citaf_txstat_t;
endpackage : citaf_pkg

// ### verilog/citaf_core.sv
// CAN interrupt enables, transmit abort handshake, acceptance filter, AXI4-Lite slave
//
// Added by the designer: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
// Function
// R1 - Enables gate wakeup, error, receive interrupts
// R2 - Receive enables held reset during soft reset
// R3 - Abort acks read-only; empty flags write-one-clear
// R4 - Transmit flags reset and held in soft reset
// R5 - Empty flag set on send or abort
// R6 - Software loads buffer then clears empty flag
// R7 - Software avoids writing non-empty buffers
// R8 - Clear empty clears ack; set clears request
// R9 - Abort granted only if not started/failed
// R10 - CPU cannot clear abort request bits
// R11 - Software never clears empty and aborts together
// R12 - Empty enable gates per-buffer empty interrupt
// R13 - Transmit control held reset during soft reset
// R14 - Layout field selects filter split or closed
// R15 - Hit index updated on foreground copy
// R16 - Acceptance registers writable only in soft reset
// R17 - Error counters shown read-only
// R18 - Software reads counters only sleep/soft reset
// R19 - Every message buffered; only accepted signalled
// R20 - Extended uses four pairs, standard two
// R21 - Mask one ignores bit, zero must match
// R22 - Standard ids need low mask bits set
// R23 - Full flag blocks foreground exchange
// R24 - Error interrupt is OR of enabled flags
module citaf_core
(
  input  wire logic                    clk_sys,
  input  wire logic                    reset,
  input  wire logic [7:0]              s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [7:0]              s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire logic                    soft_reset_request,
  input  wire citaf_pkg::citaf_rxflags_t rxFlags,
  input  wire logic [7:0]              rxErrorCount,
  input  wire logic [7:0]              txErrorCount,
  input  wire citaf_pkg::citaf_txstat_t txStat,
  input  wire logic                    bgValid,
  input  wire logic                    bgExtended,
  input  wire logic [31:0]             bgIdentifier,
  output logic                         fgLoad,
  output logic                         msgAccepted,
  output logic [2:0]                   abortRequest,
  output logic [2:0]                   txEmpty,
  output logic                         wakeupIrq,
  output logic                         errorIrq,
  output logic                         rxIrq,
  output logic                         txEmptyIrq
);
  logic [7:0]  rxIrqEnable;
  logic [2:0]  txEmptyIrqEn;
  logic [2:0]  abortAck;
  logic [1:0]  acceptLayout;
  logic [1:0]  filterHitIndex;
  logic [7:0]  acceptCode [4];
  logic [7:0]  acceptMask [4];
  logic        wrPend;
  logic [7:0]  wrAddr;
  logic        awHeld;
  logic        wHeld;
  logic [31:0] wData;
  logic [3:0]  wStrb;
  logic        wrFire;
  logic        wrHit;
  logic [31:0] next_rdata;
  logic        rdHit;
  logic [3:0]  matchByte;
  logic        accept;
  logic [1:0]  hit;
  logic [2:0]  abortGrant;
  logic [2:0] next_txEmpty;
  logic [2:0] clrTxe;
  logic [2:0] setAbtrq;

  // Byte compare with mask; a one in the mask makes the bit irrelevant
  function automatic logic byteMatch(input logic [7:0] id, input logic [7:0] code,
                                     input logic [7:0] mask);
    byteMatch = &((~(id ^ code)) | mask); // R21
  endfunction : byteMatch

  function automatic logic isAddr(input logic [7:0] a, input logic [7:0] off);
    isAddr = (a == off);
  endfunction : isAddr

  // Write address and data may arrive in either order
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      awHeld <= 1'b0;
      wHeld  <= 1'b0;
      wrAddr <= 8'h00;
      wData  <= 32'h0000_0000;
      wStrb  <= 4'h0;
    end
    else if (wrFire)
    begin
      awHeld <= 1'b0;
      wHeld  <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld <= 1'b1;
        wrAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
    end
  end

  assign wrFire = awHeld && wHeld && !s_axi_bvalid;
  assign wrPend = wrFire && wStrb[0];

  // Ready outputs registered; each lane accepts one beat per write
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !awHeld && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready  <= !wHeld && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  // Write decode; unmapped addresses answer SLVERR
  always_comb
  begin
    wrHit = isAddr(wrAddr, citaf_pkg::OFF_RX_IRQ_ENABLE) ||
            isAddr(wrAddr, citaf_pkg::OFF_TX_FLAGS) ||
            isAddr(wrAddr, citaf_pkg::OFF_TX_CONTROL) ||
            isAddr(wrAddr, citaf_pkg::OFF_ACCEPT_CONTROL) ||
            isAddr(wrAddr, citaf_pkg::OFF_RX_ERROR_COUNT) ||
            isAddr(wrAddr, citaf_pkg::OFF_TX_ERROR_COUNT) ||
            isAddr(wrAddr, citaf_pkg::OFF_MODULE_STATUS);
    for (int i = 0; i < 4; i++)
    begin
      if (isAddr(wrAddr, citaf_pkg::OFF_ACCEPT_CODE_0 + 8'(4 * i)) ||
          isAddr(wrAddr, citaf_pkg::OFF_ACCEPT_MASK_0 + 8'(4 * i)))
        wrHit = 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= citaf_pkg::RESP_OKAY;
    end
    else if (wrFire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wrHit ? citaf_pkg::RESP_OKAY : citaf_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Receive interrupt enables, cleared while soft reset is requested
  always_ff @(posedge clk_sys)
  begin
    if (reset || soft_reset_request) // R2
      rxIrqEnable <= citaf_pkg::RST_RX_IRQ_ENABLE;
    else if (wrPend && isAddr(wrAddr, citaf_pkg::OFF_RX_IRQ_ENABLE))
      rxIrqEnable <= wData[7:0];
  end

  // Transmit control: enables writable, abort requests set-only
  assign setAbtrq = (wrPend && isAddr(wrAddr, citaf_pkg::OFF_TX_CONTROL)) ?
                    wData[citaf_pkg::POS_ABORT_REQUEST +: 3] : 3'h0;
  assign clrTxe   = (wrPend && isAddr(wrAddr, citaf_pkg::OFF_TX_FLAGS)) ?
                    wData[citaf_pkg::POS_TXE +: 3] : 3'h0;

  always_ff @(posedge clk_sys)
  begin
    if (reset || soft_reset_request) // R13
      txEmptyIrqEn <= 3'h0;
    else if (wrPend && isAddr(wrAddr, citaf_pkg::OFF_TX_CONTROL))
      txEmptyIrqEn <= wData[citaf_pkg::POS_TXE_IE +: 3];
  end

  // Grant only while the engine says the buffer may still be pulled back
  assign abortGrant = abortRequest & ~txEmpty & txStat.abortable; // R9

  always_ff @(posedge clk_sys)
  begin
    if (reset || soft_reset_request) // R13
      abortRequest <= 3'h0;
    else
      // Software can only set; the bit falls when the empty flag rises
      abortRequest <= (abortRequest | (setAbtrq & ~txEmpty)) & ~next_txEmpty; // R10 R8
  end

  // Empty flags: hardware set wins over the software clear
  assign next_txEmpty = (txEmpty & ~clrTxe) | txStat.sent | abortGrant; // R3 R5

  always_ff @(posedge clk_sys)
  begin
    if (reset || soft_reset_request) // R4
      txEmpty <= citaf_pkg::RST_TX_EMPTY;
    else
      txEmpty <= next_txEmpty; // R5
  end

  // Abort acknowledge: set on grant, cleared with the empty flag
  always_ff @(posedge clk_sys)
  begin
    if (reset || soft_reset_request) // R4
      abortAck <= 3'h0;
    else
      abortAck <= (abortAck & ~(clrTxe & txEmpty)) | abortGrant; // R8 R9
  end

  // Acceptance control and filter setup, locked outside soft reset
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      acceptLayout <= 2'h0;
    else if (wrPend && soft_reset_request &&
             isAddr(wrAddr, citaf_pkg::OFF_ACCEPT_CONTROL)) // R16
      acceptLayout <= wData[citaf_pkg::POS_LAYOUT +: 2];
  end

  generate
    for (genvar g = 0; g < 4; g++)
    begin : gFilter
      always_ff @(posedge clk_sys)
      begin
        if (reset)
        begin
          acceptCode[g] <= citaf_pkg::RST_BYTE;
          acceptMask[g] <= citaf_pkg::RST_BYTE;
        end
        else if (wrPend && soft_reset_request) // R16
        begin
          if (isAddr(wrAddr, citaf_pkg::OFF_ACCEPT_CODE_0 + 8'(4 * g)))
            acceptCode[g] <= wData[7:0];
          if (isAddr(wrAddr, citaf_pkg::OFF_ACCEPT_MASK_0 + 8'(4 * g)))
            acceptMask[g] <= wData[7:0];
        end
      end
      // Identifier byte g lives in bits 31-8g downward
      assign matchByte[g] = byteMatch(bgIdentifier[31 - 8 * g -: 8],
                                      acceptCode[g], acceptMask[g]); // R20
    end
  endgenerate

  // Filter decision and hit index by layout
  always_comb
  begin
    accept = 1'b0;
    hit    = 2'd0;
    unique case (citaf_pkg::citaf_layout_t'(acceptLayout)) // R14
      citaf_pkg::CITAF_ONE32:
        // Standard ids only use the first two pairs
        accept = matchByte[0] & matchByte[1] &
                 (~bgExtended | (matchByte[2] & matchByte[3])); // R20
      citaf_pkg::CITAF_TWO16:
      begin
        // Two halves, checked in pairs; lowest hit wins
        if (matchByte[0] & matchByte[1])
          accept = 1'b1;
        else if (matchByte[2] & matchByte[3])
        begin
          accept = 1'b1;
          hit    = 2'd1;
        end
      end
      citaf_pkg::CITAF_FOUR8:
      begin
        for (int i = 3; i >= 0; i--)
        begin
          if (matchByte[i])
          begin
            accept = 1'b1;
            hit    = 2'(i);
          end
        end
      end
      citaf_pkg::CITAF_CLOSED:
        accept = 1'b0; // R14
    endcase
  end

  // Foreground copy only for accepted messages and a free foreground buffer
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      fgLoad         <= 1'b0;
      msgAccepted    <= 1'b0;
      filterHitIndex <= 2'd0;
    end
    else
    begin
      msgAccepted <= bgValid && accept; // R19
      fgLoad      <= bgValid && accept && !rxFlags.rxFull && !fgLoad; // R23
      if (bgValid && accept && !rxFlags.rxFull && !fgLoad)
        filterHitIndex <= hit; // R15
    end
  end

  // Interrupt outputs, registered
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      wakeupIrq  <= 1'b0;
      errorIrq   <= 1'b0;
      rxIrq      <= 1'b0;
      txEmptyIrq <= 1'b0;
    end
    else
    begin
      wakeupIrq  <= rxFlags.wakeup & rxIrqEnable[7]; // R1
      errorIrq   <= |(rxFlags[6:1] & rxIrqEnable[6:1]); // R1 R24
      rxIrq      <= rxFlags.rxFull & rxIrqEnable[0]; // R1
      txEmptyIrq <= |(txEmpty & txEmptyIrqEn); // R12
    end
  end

  // Read channel; one read at a time
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    rdHit      = 1'b1;
    unique case (s_axi_araddr)
      citaf_pkg::OFF_RX_IRQ_ENABLE:  next_rdata[7:0] = rxIrqEnable;
      citaf_pkg::OFF_TX_FLAGS:
        next_rdata[7:0] = {1'b0, abortAck, 1'b0, txEmpty}; // R3
      citaf_pkg::OFF_TX_CONTROL:
        next_rdata[7:0] = {1'b0, abortRequest, 1'b0, txEmptyIrqEn};
      citaf_pkg::OFF_ACCEPT_CONTROL:
        next_rdata[7:0] = {2'b00, acceptLayout, 2'b00, filterHitIndex};
      citaf_pkg::OFF_RX_ERROR_COUNT: next_rdata[7:0] = rxErrorCount; // R17
      citaf_pkg::OFF_TX_ERROR_COUNT: next_rdata[7:0] = txErrorCount; // R17
      citaf_pkg::OFF_MODULE_STATUS:  next_rdata[7:0] = rxFlags;
      default:
      begin
        rdHit = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
          if (isAddr(s_axi_araddr, citaf_pkg::OFF_ACCEPT_CODE_0 + 8'(4 * i)))
          begin
            next_rdata[7:0] = acceptCode[i];
            rdHit = 1'b1;
          end
          if (isAddr(s_axi_araddr, citaf_pkg::OFF_ACCEPT_MASK_0 + 8'(4 * i)))
          begin
            next_rdata[7:0] = acceptMask[i];
            rdHit = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= citaf_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= next_rdata;
        s_axi_rresp  <= rdHit ? citaf_pkg::RESP_OKAY : citaf_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Checks
  a_rxen_softreset: assert property (@(posedge clk_sys) disable iff (reset)
    $past(soft_reset_request) |-> rxIrqEnable == 8'h00) // R2
    else $error("receive enables not held in soft reset");
  a_txe_onlyclear: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(txEmpty[1]) && !$past(soft_reset_request) |->
      $past(txStat.sent[1] | abortGrant[1])) // R5
    else $error("empty flag rose without cause");
  a_ack_follows: assert property (@(posedge clk_sys) disable iff (reset)
    $fell(txEmpty[1]) && !$past(soft_reset_request) |-> !abortAck[1]) // R8
    else $error("abort ack survived empty clear");
  a_abort_request_drop: assert property (@(posedge clk_sys) disable iff (reset)
    txEmpty[1] |-> !abortRequest[1]) // R8
    else $error("abort request with empty flag set");
  a_abort_request_hold: assert property (@(posedge clk_sys) disable iff (reset || soft_reset_request)
    abortRequest[1] && !next_txEmpty[1] |=> abortRequest[1]) // R10
    else $error("abort request lost without empty flag");
  a_grant_cond: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(abortAck[1]) |-> $past(txStat.abortable[1] && abortRequest[1])) // R9
    else $error("abort granted while not abortable");
  a_txeirq_gate: assert property (@(posedge clk_sys) disable iff (reset)
    txEmptyIrq |-> $past(|(txEmpty & txEmptyIrqEn))) // R12
    else $error("transmit empty interrupt without enabled flag");
  a_filter_closed: assert property (@(posedge clk_sys) disable iff (reset)
    acceptLayout == 2'd3 && $past(acceptLayout) == 2'd3 |=> !fgLoad) // R14
    else $error("foreground reloaded with filter closed");
  a_full_blocks: assert property (@(posedge clk_sys) disable iff (reset)
    $past(rxFlags.rxFull) |-> !fgLoad) // R23
    else $error("exchange while receive buffer full");
  a_accept_lock: assert property (@(posedge clk_sys) disable iff (reset)
    !$past(soft_reset_request) |-> $stable(acceptLayout)) // R16
    else $error("acceptance control changed outside soft reset");
  a_err_irq: assert property (@(posedge clk_sys) disable iff (reset)
    ##1 errorIrq == $past(|(rxFlags[6:1] & rxIrqEnable[6:1]))) // R24
    else $error("error interrupt does not follow enabled flags");
endmodule : citaf_core

// ### verif/citaf_tx_model.sv
// Transmit engine model on the far side of the abort handshake
`timescale 1ns/1ps
module citaf_tx_model
(
  input  wire logic                clk_sys,
  input  wire logic                reset,
  input  wire logic [2:0]          txEmpty,
  input  wire logic [2:0]          sendNow,
  input  wire logic [2:0]          started,
  output citaf_pkg::citaf_txstat_t txStat
);
  logic [2:0] sentPulse;

  // A frame already on the wire can no longer be withdrawn
  assign txStat = {sentPulse, ~txEmpty & ~started};
  // Success pulse, one cycle wide, only for a scheduled buffer
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      sentPulse <= 3'h0;
    else
      sentPulse <= sendNow & ~txEmpty;
  end
endmodule : citaf_tx_model

// ### verif/tb_top.sv
// Self-checking bench for the CAN interrupt, abort and filter block
`timescale 1ns/1ps
module tb_top;
  typedef struct packed
  {
    logic [1:0]  layout;
    logic        ext;
    logic [31:0] id;
    logic        acc;
    logic [1:0]  hit;
  } citaf_row_t;

  // Code 12 34 56 78, only mask byte 1 low bits ignored
  localparam citaf_row_t ROWS [8] = '{
    '{2'd0, 1'b1, 32'h12345678, 1'b1, 2'd0},
    '{2'd0, 1'b1, 32'h12345679, 1'b0, 2'd0},
    '{2'd0, 1'b0, 32'h1233aaaa, 1'b1, 2'd0},
    '{2'd1, 1'b1, 32'h00005678, 1'b1, 2'd1},
    '{2'd2, 1'b1, 32'h00340000, 1'b1, 2'd1},
    '{2'd2, 1'b1, 32'h00000078, 1'b1, 2'd3},
    '{2'd2, 1'b1, 32'h00000000, 1'b0, 2'd0},
    '{2'd3, 1'b1, 32'h12345678, 1'b0, 2'd0}};
  localparam logic [7:0] RA [4] = '{8'h00, 8'h04, 8'h08, 8'h0c};
  localparam logic [7:0] RE [4] = '{8'h00, 8'h07, 8'h00, 8'h00};

  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        soft_reset_request = 1'b0;
  logic        bgValid = 1'b0;
  logic        bgExtended = 1'b0;
  logic [31:0] bgIdentifier = 32'h0;
  logic [7:0]  rxErrorCount = 8'h61;
  logic [7:0]  txErrorCount = 8'h80;
  logic [2:0]  sendNow = 3'h0;
  logic [2:0]  started = 3'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, lastResp;
  logic [31:0] s_axi_rdata, rdVal;
  logic        fgLoad, msgAccepted, wakeupIrq, errorIrq, rxIrq, txEmptyIrq, acc, ld;
  logic [2:0]  abortRequest, txEmpty;
  int          n_mismatch = 0;
  int          num_checks = 0;
  citaf_pkg::citaf_rxflags_t rxFlags = 8'h00;
  citaf_pkg::citaf_txstat_t  txStat;

  citaf_core DUT (.clk_sys, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .soft_reset_request, .rxFlags,
    .rxErrorCount, .txErrorCount, .txStat, .bgValid, .bgExtended, .bgIdentifier, .fgLoad,
    .msgAccepted, .abortRequest, .txEmpty, .wakeupIrq, .errorIrq, .rxIrq, .txEmptyIrq);

  citaf_tx_model farEnd (.clk_sys, .reset, .txEmpty, .sendNow, .started, .txStat);

  // 20 MHz system clock
  always #25 clk_sys = ~clk_sys;

  task results();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (num_checks > 0 && n_mismatch == 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task tmo();
    n_mismatch++;
    $display("mismatch bus answer expected response seen none");
    results();
  endtask : tmo

  // Address and data offered together, each released once taken
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic b;
    int   n;
    b = 1'b0;
    n = 0;
    @(posedge clk_sys);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!b && n < 50)
    begin
      @(posedge clk_sys);
      n++;
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      b = s_axi_bvalid;
    end
    s_axi_bready <= 1'b0;
    lastResp = s_axi_bresp;
    if (!b)
      tmo();
  endtask : wr

  task rd(input logic [7:0] a);
    logic v;
    int   n;
    v = 1'b0;
    n = 0;
    @(posedge clk_sys);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!v && n < 50)
    begin
      @(posedge clk_sys);
      n++;
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      v = s_axi_rvalid;
    end
    s_axi_rready <= 1'b0;
    rdVal = s_axi_rdata;
    lastResp = s_axi_rresp;
    if (!v)
      tmo();
  endtask : rd

  task sr(input logic v);
    @(posedge clk_sys);
    soft_reset_request <= v;
  endtask : sr

  // One background message, then watch the filter outcome
  task send(input logic e, input logic [31:0] id);
    acc = 1'b0;
    ld = 1'b0;
    @(posedge clk_sys);
    bgValid      <= 1'b1;
    bgExtended   <= e;
    bgIdentifier <= id;
    @(posedge clk_sys);
    bgValid <= 1'b0;
    repeat (4)
    begin
      @(posedge clk_sys);
      acc = acc | msgAccepted;
      ld = ld | fgLoad;
    end
  endtask : send

  initial
  begin
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (2) @(posedge clk_sys);
    foreach (RA[i])
    begin
      rd(RA[i]);
      chk("reset value", RE[i], rdVal);
    end
    rd(8'h18);
    chk("unmapped response", citaf_pkg::RESP_SLVERR, lastResp);
    wr(8'h18, 8'h00);
    chk("unmapped write response", citaf_pkg::RESP_SLVERR, lastResp);
    // Counters read only while held in soft reset
    sr(1'b1);
    rd(citaf_pkg::OFF_RX_ERROR_COUNT);
    chk("rx error count", 8'h61, rdVal);
    wr(citaf_pkg::OFF_TX_ERROR_COUNT, 8'hff);
    rd(citaf_pkg::OFF_TX_ERROR_COUNT);
    chk("tx error count", 8'h80, rdVal);
    for (int i = 0; i < 4; i++)
    begin
      wr(citaf_pkg::OFF_ACCEPT_CODE_0 + 8'(4 * i), 8'(32'h12345678 >> (24 - 8 * i)));
      wr(citaf_pkg::OFF_ACCEPT_MASK_0 + 8'(4 * i), (i == 1) ? 8'h07 : 8'h00);
    end
    foreach (ROWS[i])
    begin
      sr(1'b1);
      wr(citaf_pkg::OFF_ACCEPT_CONTROL, {2'b00, ROWS[i].layout, 4'h0});
      sr(1'b0);
      send(ROWS[i].ext, ROWS[i].id);
      chk("accepted", ROWS[i].acc, acc);
      chk("loaded", ROWS[i].acc, ld);
      rd(citaf_pkg::OFF_ACCEPT_CONTROL);
      chk("layout", ROWS[i].layout, rdVal[5:4]);
      if (ROWS[i].acc)
        chk("hit index", ROWS[i].hit, rdVal[1:0]);
    end
    sr(1'b1);
    wr(citaf_pkg::OFF_ACCEPT_CONTROL, 8'h00);
    sr(1'b0);
    wr(citaf_pkg::OFF_ACCEPT_CODE_0, 8'hff);
    chk("locked write response", citaf_pkg::RESP_OKAY, lastResp);
    rd(citaf_pkg::OFF_ACCEPT_CODE_0);
    chk("code locked", 8'h12, rdVal);
    rxFlags <= 8'h01;
    send(1'b1, 32'h12345678);
    chk("load while full", 1'b0, ld);
    rxFlags <= 8'h00;
    send(1'b1, 32'h12345678);
    chk("load after release", 1'b1, ld);
    // Walk a single enable across all flags raised
    rxFlags <= 8'hff;
    for (int i = 0; i < 8; i++)
    begin
      wr(citaf_pkg::OFF_RX_IRQ_ENABLE, 8'h01 << i);
      repeat (2) @(posedge clk_sys);
      chk("irq lines", {i == 7, i > 0 && i < 7, i == 0}, {wakeupIrq, errorIrq, rxIrq});
    end
    wr(citaf_pkg::OFF_RX_IRQ_ENABLE, 8'h02);
    rxFlags <= 8'h02;
    rd(citaf_pkg::OFF_RX_IRQ_ENABLE);
    chk("enable readback", 8'h02, rdVal);
    chk("overrun irq", 1'b1, errorIrq);
    rxFlags <= 8'h04;
    repeat (3) @(posedge clk_sys);
    chk("masked busoff", 1'b0, errorIrq);
    wr(citaf_pkg::OFF_RX_IRQ_ENABLE, 8'hff);
    sr(1'b1);
    wr(citaf_pkg::OFF_RX_IRQ_ENABLE, 8'hff);
    rd(citaf_pkg::OFF_RX_IRQ_ENABLE);
    chk("enables in soft reset", 8'h00, rdVal);
    chk("irqs in soft reset", 3'h0, {wakeupIrq, errorIrq, rxIrq});
    sr(1'b0);
    rxFlags <= 8'h00;
    // Abort handshake on buffer 1, granted then refused
    wr(citaf_pkg::OFF_TX_CONTROL, 8'h02);
    wr(citaf_pkg::OFF_TX_FLAGS, 8'h00);
    rd(citaf_pkg::OFF_TX_FLAGS);
    chk("zero write", 8'h07, rdVal);
    chk("empty irq", 1'b1, txEmptyIrq);
    wr(citaf_pkg::OFF_TX_FLAGS, 8'h72);
    rd(citaf_pkg::OFF_TX_FLAGS);
    chk("clear one flag", 8'h05, rdVal);
    chk("scheduled irq", 1'b0, txEmptyIrq);
    wr(citaf_pkg::OFF_TX_CONTROL, 8'h22);
    rd(citaf_pkg::OFF_TX_FLAGS);
    chk("abort granted", 8'h27, rdVal);
    chk("request dropped", 3'h0, abortRequest);
    chk("grant irq", 1'b1, txEmptyIrq);
    wr(citaf_pkg::OFF_TX_FLAGS, 8'h02);
    rd(citaf_pkg::OFF_TX_FLAGS);
    chk("ack cleared", 8'h05, rdVal);
    started <= 3'b010;
    wr(citaf_pkg::OFF_TX_CONTROL, 8'h22);
    wr(citaf_pkg::OFF_TX_CONTROL, 8'h02);
    rd(citaf_pkg::OFF_TX_CONTROL);
    chk("request kept", 8'h22, rdVal);
    chk("abort refused", 3'b101, txEmpty);
    sendNow <= 3'b010;
    @(posedge clk_sys);
    sendNow <= 3'b000;
    rd(citaf_pkg::OFF_TX_FLAGS);
    chk("sent", 8'h07, rdVal);
    chk("request cleared", 3'h0, abortRequest);
    wr(citaf_pkg::OFF_TX_FLAGS, 8'h01);
    sr(1'b1);
    wr(citaf_pkg::OFF_TX_CONTROL, 8'h07);
    rd(citaf_pkg::OFF_TX_CONTROL);
    chk("control in soft reset", 8'h00, rdVal);
    chk("flags in soft reset", 3'h7, txEmpty);
    sr(1'b0);
    results();
  end
endmodule : tb_top
